// [rtl/flash_cfg_map.vh]
// opcodes, status field positions, reset values and array geometry
// assumes: included by the flash configuration and protection logic
`ifndef FLASH_CFG_MAP_VH
`define FLASH_CFG_MAP_VH
`define OP_WREN 8'h06
`define OP_VWREN 8'h50
`define OP_WRDI 8'h04
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_SUSP 8'h75
`define OP_RESUME 8'h7A
`define OP_EN4B 8'hB7
`define OP_EX4B 8'hE9
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_SE 8'h20
`define OP_BE 8'hD8
`define OP_CE 8'hC7
`define OP_CE2 8'h60
`define OP_SECPG 8'h42
`define OP_SECER 8'h44
`define OP_BLKLK 8'h36
`define OP_BLKUN 8'h39
`define SR1_TB 6
`define SR1_BP_HI 5
`define SR1_BP_LO 2
`define SR2_CMP 6
`define SR2_LB_HI 5
`define SR2_LB_LO 3
`define SR2_QE 1
`define SR3_DRV_HI 6
`define SR3_DRV_LO 5
`define SR3_WPS 2
`define SR3_ADP 1
`define RST_BP 4'h0
`define RST_TB 1'b0
`define RST_CMP 1'b0
`define RST_LB 3'h0
`define RST_QE 1'b0
`define RST_ADP 1'b0
`define RST_WPS 1'b0
`define RST_DRV 2'h3
`define BLK_AW 9
`define BLK_HI 24
`define BLK_LO 16
`define SEC_HI 13
`define SEC_LO 12
`endif

// [rtl/block_lock_mem.v]
// per-block lock bits with registered read and an any-locked summary
// assumes: single clock, write and set-all pulses from the same domain
`timescale 1ns/100ps
module block_lock_mem #(
   parameter AW = 9
) (
   input wire sys_clk,
   input wire rst_n,
   input wire set_all,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire wr_bit,
   input wire [AW-1:0] rd_addr,
   output reg rd_bit,
   output reg any_set
);
   localparam DEPTH = 1 << AW;
   reg [DEPTH-1:0] lock_q;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q <= {DEPTH{1'b1}};
         rd_bit <= 1'b1;
         any_set <= 1'b1;
      end else begin
         if (set_all) begin
            lock_q <= {DEPTH{1'b1}};
         end else if (wr_en) begin
            lock_q[wr_addr] <= wr_bit;
         end
         rd_bit <= lock_q[rd_addr];
         any_set <= |lock_q;
      end
   end
endmodule // block_lock_mem

// [rtl/flash_cfg_protect.v]
// status/config bits and array write-protection decode of a serial flash
// assumes: mode-0 serial host; sclk, cs_n, di asynchronous to sys_clk
// and sclk at least eight times slower than sys_clk
`timescale 1ns/100ps
`include "flash_cfg_map.vh"
module flash_cfg_protect #(
   parameter QE_INIT = `RST_QE,
   parameter ADP_INIT = `RST_ADP
) (
   input wire sys_clk,
   input wire rst_n,
   input wire sclk,
   input wire cs_n,
   input wire di,
   output reg do_out,
   output reg do_oe,
   output reg quad_io_enable,
   output reg hold_active,
   output reg [1:0] drive_strength,
   output reg four_byte_mode,
   output reg op_go,
   output reg [7:0] op_code,
   output reg [24:0] op_addr,
   output reg op_blocked
);
   localparam S_CMD = 5'b00001;
   localparam S_ADDR = 5'b00010;
   localparam S_WDAT = 5'b00100;
   localparam S_RDAT = 5'b01000;
   localparam S_SKIP = 5'b10000;

   // protected-region decode shared by single-block and chip checks
   function prot_dec;
      input [8:0] blk;
      input tb;
      input [3:0] bp;
      input cmp;
      reg [9:0] sz;
      reg hit;
      begin
         sz = 10'h001 << (bp - 4'h1);
         if (bp == 4'h0) begin
            hit = 1'b0;
         end else if (bp[3] & (bp[2] | bp[1])) begin
            hit = 1'b1;
         end else if (tb) begin
            hit = ({1'b0, blk} < sz);
         end else begin
            hit = ({1'b0, blk} >= (10'h200 - sz));
         end
         prot_dec = hit ^ cmp;
      end
   endfunction

   reg [1:0] sclk_s, cs_s, di_s;
   reg sclk_d, cs_d;
   reg [4:0] state_q;
   reg [2:0] bit_q, nbyte_q;
   reg [7:0] sh_q, cmd_q, dat_q, out_q;
   reg [31:0] addr_q;
   reg wel_q, vwel_q, rst_en_q, init_q;
   reg sus_q, cmp_q, tb_q, wps_q, adp_q;
   reg [3:0] bp_q;
   reg [2:0] lb_q;
   reg lk_set_all, lk_wr, lk_bit;

   wire rise = sclk_s[1] & ~sclk_d;
   wire fall = ~sclk_s[1] & sclk_d;
   wire sel = ~cs_s[1];
   wire cs_rise = cs_s[1] & ~cs_d;
   wire [7:0] sh_d = {sh_q[6:0], di_s[1]};
   wire [2:0] alast = four_byte_mode ? 3'h3 : 3'h2;
   // three-byte mode reaches only the lower half: no extended register
   wire [24:0] ea = four_byte_mode ? addr_q[24:0] : {1'b0, addr_q[23:0]};
   wire [8:0] blk = ea[`BLK_HI:`BLK_LO];
   wire [1:0] sec_n = ea[`SEC_HI:`SEC_LO];
   wire lk_rd, lk_any;
   wire prot = wps_q ? lk_rd : prot_dec(blk, tb_q, bp_q, cmp_q);
   wire any0 = prot_dec(9'h000, tb_q, bp_q, cmp_q) |
      prot_dec(9'h1FF, tb_q, bp_q, cmp_q);
   wire prot_all = wps_q ? lk_any : any0;
   wire sec_lk = (sec_n == 2'h0) | (sec_n == 2'h1 & lb_q[0]) |
      (sec_n == 2'h2 & lb_q[1]) | (sec_n == 2'h3 & lb_q[2]);
   wire addr_ok = (state_q == S_WDAT);
   wire data_ok = addr_ok & (nbyte_q != 3'h0);
   wire wr_ok = (wel_q | vwel_q) & data_ok;
   // reserved bits and the out-of-scope bits read as zero
   wire [7:0] sr1 = {1'b0, tb_q, bp_q, wel_q, 1'b0};
   wire [7:0] sr2 = {sus_q, cmp_q, lb_q, 1'b0, quad_io_enable, 1'b0};
   wire [7:0] sr3 = {1'b0, drive_strength, 2'b00, wps_q, adp_q,
      four_byte_mode};

   block_lock_mem #(
      .AW(`BLK_AW)
   ) u_locks (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_all(lk_set_all),
      .wr_en(lk_wr),
      .wr_addr(blk),
      .wr_bit(lk_bit),
      .rd_addr(blk),
      .rd_bit(lk_rd),
      .any_set(lk_any)
   );

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s <= 2'b00;
         cs_s <= 2'b11;
         di_s <= 2'b00;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[0], sclk};
         cs_s <= {cs_s[0], cs_n};
         di_s <= {di_s[0], di};
         sclk_d <= sclk_s[1];
         cs_d <= cs_s[1];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_CMD;
         bit_q <= 3'h0;
         nbyte_q <= 3'h0;
         sh_q <= 8'h00;
         cmd_q <= 8'h00;
         dat_q <= 8'h00;
         out_q <= 8'h00;
         addr_q <= 32'h0000_0000;
         wel_q <= 1'b0;
         vwel_q <= 1'b0;
         rst_en_q <= 1'b0;
         init_q <= 1'b1;
         sus_q <= 1'b0;
         cmp_q <= `RST_CMP;
         tb_q <= `RST_TB;
         bp_q <= `RST_BP;
         lb_q <= `RST_LB;
         wps_q <= `RST_WPS;
         adp_q <= ADP_INIT;
         lk_set_all <= 1'b0;
         lk_wr <= 1'b0;
         lk_bit <= 1'b0;
         do_out <= 1'b0;
         do_oe <= 1'b0;
         quad_io_enable <= QE_INIT;
         hold_active <= 1'b1;
         drive_strength <= `RST_DRV;
         four_byte_mode <= 1'b0;
         op_go <= 1'b0;
         op_code <= 8'h00;
         op_addr <= 25'h000_0000;
         op_blocked <= 1'b0;
      end else begin
         op_go <= 1'b0;
         op_blocked <= 1'b0;
         lk_set_all <= 1'b0;
         lk_wr <= 1'b0;
         hold_active <= ~quad_io_enable;
         if (init_q) begin
            four_byte_mode <= adp_q;
            init_q <= 1'b0;
         end
         if (!sel) begin
            state_q <= S_CMD;
            bit_q <= 3'h0;
            do_oe <= 1'b0;
         end
         if (sel && rise) begin
            sh_q <= sh_d;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
               case (state_q)
                  S_CMD: begin
                     cmd_q <= sh_d;
                     nbyte_q <= 3'h0;
                     case (sh_d)
                        `OP_RDSR1: begin
                           state_q <= S_RDAT;
                           out_q <= sr1;
                        end
                        `OP_RDSR2: begin
                           state_q <= S_RDAT;
                           out_q <= sr2;
                        end
                        `OP_RDSR3: begin
                           state_q <= S_RDAT;
                           out_q <= sr3;
                        end
                        `OP_WRSR1, `OP_WRSR2, `OP_WRSR3: begin
                           state_q <= S_WDAT;
                        end
                        `OP_QPP: begin
                           state_q <= quad_io_enable ?
                              S_ADDR : S_SKIP;
                        end
                        `OP_PP, `OP_SE, `OP_BE, `OP_SECPG, `OP_SECER,
                        `OP_BLKLK, `OP_BLKUN: begin
                           state_q <= S_ADDR;
                        end
                        default: begin
                           state_q <= S_SKIP;
                        end
                     endcase
                  end
                  S_ADDR: begin
                     addr_q <= {addr_q[23:0], sh_d};
                     nbyte_q <= nbyte_q + 3'h1;
                     if (nbyte_q == alast) begin
                        state_q <= S_WDAT;
                        nbyte_q <= 3'h0;
                     end
                  end
                  S_WDAT: begin
                     if (nbyte_q == 3'h0) begin
                        dat_q <= sh_d;
                     end
                     if (nbyte_q != 3'h7) begin
                        nbyte_q <= nbyte_q + 3'h1;
                     end
                  end
                  default: begin
                     state_q <= state_q;
                  end
               endcase
            end
         end
         // status bytes repeat for as long as the host keeps clocking
         if (sel && fall && state_q == S_RDAT) begin
            do_out <= out_q[7];
            out_q <= {out_q[6:0], out_q[7]};
            do_oe <= 1'b1;
         end
         // writes and single-byte commands need a whole number of bytes
         if (cs_rise && bit_q == 3'h0 && state_q != S_CMD) begin
            rst_en_q <= (cmd_q == `OP_RSTEN);
            case (cmd_q)
               `OP_WREN: begin
                  wel_q <= 1'b1;
                  vwel_q <= 1'b0;
               end
               `OP_VWREN: begin
                  vwel_q <= 1'b1;
               end
               `OP_WRDI: begin
                  wel_q <= 1'b0;
                  vwel_q <= 1'b0;
               end
               `OP_SUSP: begin
                  sus_q <= 1'b1;
               end
               `OP_RESUME: begin
                  sus_q <= 1'b0;
               end
               `OP_EN4B: begin
                  four_byte_mode <= 1'b1;
               end
               `OP_EX4B: begin
                  four_byte_mode <= 1'b0;
               end
               `OP_RST: begin
                  if (rst_en_q) begin
                     lk_set_all <= 1'b1;
                     init_q <= 1'b1;
                     sus_q <= 1'b0;
                     wel_q <= 1'b0;
                     vwel_q <= 1'b0;
                  end
               end
               `OP_WRSR1: begin
                  if (wr_ok) begin
                     tb_q <= dat_q[`SR1_TB];
                     bp_q <= dat_q[`SR1_BP_HI:`SR1_BP_LO];
                     wel_q <= 1'b0;
                     vwel_q <= 1'b0;
                  end
               end
               `OP_WRSR2: begin
                  if (wr_ok) begin
                     cmp_q <= dat_q[`SR2_CMP];
                     quad_io_enable <= dat_q[`SR2_QE];
                     // one-time bits: only the non-volatile path, only set
                     if (wel_q) begin
                        lb_q <= lb_q | dat_q[`SR2_LB_HI:`SR2_LB_LO];
                     end
                     wel_q <= 1'b0;
                     vwel_q <= 1'b0;
                  end
               end
               `OP_WRSR3: begin
                  if (wr_ok) begin
                     drive_strength <= dat_q[`SR3_DRV_HI:`SR3_DRV_LO];
                     wps_q <= dat_q[`SR3_WPS];
                     if (wel_q) begin
                        adp_q <= dat_q[`SR3_ADP];
                     end
                     wel_q <= 1'b0;
                     vwel_q <= 1'b0;
                  end
               end
               `OP_BLKLK, `OP_BLKUN: begin
                  if (wel_q && addr_ok) begin
                     lk_wr <= 1'b1;
                     lk_bit <= (cmd_q == `OP_BLKLK);
                     wel_q <= 1'b0;
                  end
               end
               `OP_PP, `OP_QPP, `OP_SE, `OP_BE, `OP_CE, `OP_CE2,
               `OP_SECPG, `OP_SECER: begin
                  if (wel_q && (addr_ok || cmd_q == `OP_CE ||
                     cmd_q == `OP_CE2)) begin
                     wel_q <= 1'b0;
                     op_code <= cmd_q;
                     op_addr <= ea;
                     if (cmd_q == `OP_CE || cmd_q == `OP_CE2) begin
                        op_go <= ~prot_all;
                        op_blocked <= prot_all;
                     end else if (cmd_q == `OP_SECPG ||
                        cmd_q == `OP_SECER) begin
                        op_go <= ~sec_lk;
                        op_blocked <= sec_lk;
                     end else begin
                        op_go <= ~prot;
                        op_blocked <= prot;
                     end
                  end
               end
               default: begin
                  wel_q <= wel_q;
               end
            endcase
         end
      end
   end
endmodule // flash_cfg_protect

// [bench/flash_cfg_protect_assertions.sv]
// port checks for the flash status and protection block
// assumes: single sys_clk domain, bound to the block below
`timescale 1ns/100ps
module flash_cfg_protect_assertions (
   input logic sys_clk,
   input logic rst_n,
   input logic cs_n,
   input logic quad_io_enable,
   input logic hold_active,
   input logic [1:0] drive_strength,
   input logic four_byte_mode,
   input logic op_go,
   input logic op_blocked
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence quad_on;
      $rose(quad_io_enable);
   endsequence
   sequence quad_off;
      $fell(quad_io_enable);
   endsequence
   // updates land only after the frame has closed
   sequence frame_closed;
      cs_n && $past(cs_n, 2);
   endsequence
   a_hold_off_quad: assert property (quad_on |=> !hold_active)
      else $error("hold stays on with quad enabled");
   a_hold_on_noquad: assert property (quad_off |=> hold_active)
      else $error("hold off with quad disabled");
   a_pulse_excl: assert property (!(op_go && op_blocked))
      else $error("accepted and ignored together");
   a_go_single: assert property (op_go |=> !op_go)
      else $error("accept pulse too long");
   a_blk_single: assert property (op_blocked |=> !op_blocked)
      else $error("ignore pulse too long");
   a_op_frame_end: assert property
      ((op_go || op_blocked) |-> frame_closed)
      else $error("operation outcome inside a frame");
   a_drive_frame_end: assert property
      (!$stable(drive_strength) |-> frame_closed)
      else $error("drive field moved inside a frame");
   a_mode_frame_end: assert property
      (!$stable(four_byte_mode) |-> frame_closed)
      else $error("address mode moved inside a frame");
endmodule // flash_cfg_protect_assertions
bind flash_cfg_protect flash_cfg_protect_assertions
   u_flash_cfg_protect_assertions (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .cs_n(cs_n),
   .quad_io_enable(quad_io_enable),
   .hold_active(hold_active),
   .drive_strength(drive_strength),
   .four_byte_mode(four_byte_mode),
   .op_go(op_go),
   .op_blocked(op_blocked)
);

// [bench/spi_host_model.sv]
// host serial controller model, mode 0, msb first
// assumes: sys_clk of 100 ns; serial clock of 800 ns only inside frames
`timescale 1ns/100ps
module spi_host_model (
   input wire sys_clk,
   input wire do_out,
   output reg sclk,
   output reg cs_n,
   output reg di
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      di = 1'b0;
   end
   // half a serial period, edges kept just after sys_clk
   task half;
      begin
         repeat (4) @(posedge sys_clk);
         #1;
      end
   endtask
   task open;
      begin
         cs_n = 1'b0;
         half;
      end
   endtask
   // whole bytes only; reply sampled late in the high phase
   task xbyte(input [7:0] tx, output [7:0] rx);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1) begin
            di = tx[k];
            half;
            sclk = 1'b1;
            half;
            rx[k] = do_out;
            sclk = 1'b0;
         end
      end
   endtask
   // released data line shows the inverse, never a stale level
   task close;
      begin
         half;
         cs_n = 1'b1;
         di = ~di;
         repeat (4) half;
      end
   endtask
endmodule // spi_host_model

// [bench/test_flash_cfg_protect.sv]
// self-checking bench for the flash status and protection block
// assumes: host model drives the serial pins, checker bound separately
`timescale 1ns/100ps
module test_flash_cfg_protect;
   reg sys_clk = 1'b0;
   reg rst_n = 1'b0;
   wire sclk, cs_n, di, do_out, do_oe, quad_io_enable, hold_active;
   wire four_byte_mode, op_go, op_blocked;
   wire [1:0] drive_strength;
   wire [7:0] op_code;
   wire [24:0] op_addr;
   integer num_errors = 0;
   integer tests_run = 0;
   integer i;
   reg [7:0] r;
   reg got_go, got_blk, tb_sel, hit;
   reg [8:0] b;
   reg [9:0] n;
   always #50 sys_clk = ~sys_clk;
   flash_cfg_protect u_flash_cfg_protect (.sys_clk(sys_clk),
      .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .di(di),
      .do_out(do_out), .do_oe(do_oe), .quad_io_enable(quad_io_enable),
      .hold_active(hold_active), .drive_strength(drive_strength),
      .four_byte_mode(four_byte_mode), .op_go(op_go), .op_code(op_code),
      .op_addr(op_addr), .op_blocked(op_blocked));
   spi_host_model u_spi_host_model (.sys_clk(sys_clk), .do_out(do_out),
      .sclk(sclk), .cs_n(cs_n), .di(di));
   always @(posedge sys_clk) begin
      if (op_go) got_go <= 1'b1;
      if (op_blocked) got_blk <= 1'b1;
   end
   task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task run(input [7:0] c, input integer k, input [31:0] d);
      integer j;
      begin
         got_go = 1'b0;
         got_blk = 1'b0;
         u_spi_host_model.open;
         u_spi_host_model.xbyte(c, r);
         for (j = k - 1; j >= 0; j = j - 1)
            u_spi_host_model.xbyte(d[8*j +: 8], r);
         if (c == 8'h15 && k > 0) check(do_oe, 1'b1, "oe_on");
         u_spi_host_model.close;
      end
   endtask
   task wr(input [7:0] c, input integer k, input [31:0] d);
      begin
         run(8'h06, 0, 0);
         run(c, k, d);
      end
   endtask
   task erase(input [8:0] blk, input go);
      begin
         wr(8'hD8, 4, {7'h0, blk, 16'h0});
         check({got_go, got_blk}, {go, !go}, "outcome");
         check(op_addr, {blk, 16'h0}, "addr");
         check(op_code, 8'hD8, "opcode");
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      #8000000;
      num_errors = num_errors + 1;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      u_spi_host_model.half;
      run(8'h15, 1, 0);
      check(r, 8'h60, "sr3");
      check(do_oe, 1'b0, "oe_off");
      check({quad_io_enable, hold_active, four_byte_mode}, 3'h2, "pins");
      run(8'h35, 1, 0);
      check(r, 8'h00, "sr2");
      run(8'h75, 0, 0);
      run(8'h35, 1, 0);
      check(r, 8'h80, "sus");
      run(8'h7A, 0, 0);
      run(8'h35, 1, 0);
      check(r, 8'h00, "sus");
      // reserved and read-only bits written high on purpose
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h11, 1, {24'h0, 1'b1, i[1:0], 5'h19});
         run(8'h15, 1, 0);
         check(r, {i[1:0], 5'h0}, "sr3");
         check(drive_strength, i[1:0], "drv");
      end
      run(8'h11, 1, 8'h02);
      run(8'h50, 0, 0);
      run(8'h11, 1, 8'h62);
      run(8'h15, 1, 0);
      check(r, 8'h60, "adp");
      wr(8'h11, 1, 8'h62);
      run(8'h15, 1, 0);
      check(r, 8'h62, "adp");
      check(four_byte_mode, 1'b0, "mode");
      run(8'h66, 0, 0);
      run(8'h99, 0, 0);
      check(four_byte_mode, 1'b1, "mode");
      run(8'h15, 1, 0);
      check(r, 8'h63, "sr3");
      run(8'hE9, 0, 0);
      check(four_byte_mode, 1'b0, "mode");
      run(8'hB7, 0, 0);
      wr(8'h31, 1, 8'h10);
      wr(8'h31, 1, 8'h00);
      run(8'h35, 1, 0);
      check(r, 8'h10, "locks");
      wr(8'h31, 1, 8'h2A);
      run(8'h35, 1, 0);
      check(r, 8'h3A, "locks");
      check({quad_io_enable, hold_active}, 2'h2, "quad");
      wr(8'h32, 5, 0);
      check({got_go, got_blk}, 2'h2, "qpp");
      wr(8'h31, 1, 8'h00);
      check(hold_active, 1'b1, "hold");
      wr(8'h32, 5, 0);
      check({got_go, got_blk}, 2'h0, "qpp");
      // boundary blocks of each protect code; both directions for codes 0 to 7 only
      for (i = 0; i < 24; i = i + 1) begin
         tb_sel = i[4] ^ i[0];
         wr(8'h01, 1, {25'h0, tb_sel, i[3:0], 2'h0});
         wr(8'h31, 1, {25'h0, i[4], 6'h0});
         n = (i[3:0] == 0 || i[3:0] > 9) ? 10'h0 : 10'h1 << (i[3:0] - 1);
         b = (tb_sel ? n : 10'h200 - n) - i[1];
         hit = (i[3] & (i[2] | i[1])) | (tb_sel ? b < n : b >= 10'h200 - n);
         erase(b, !(hit ^ i[4]));
      end
      wr(8'h01, 1, 0);
      wr(8'h31, 1, 0);
      wr(8'h11, 1, 8'h66);
      erase(9'h005, 1'b0);
      wr(8'h39, 4, {7'h0, 9'h005, 16'h0});
      erase(9'h005, 1'b1);
      erase(9'h006, 1'b0);
      run(8'h66, 0, 0);
      run(8'h99, 0, 0);
      erase(9'h005, 1'b0);
      run(8'h75, 0, 0);
      rst_n = 1'b0;
      u_spi_host_model.half;
      rst_n = 1'b1;
      u_spi_host_model.half;
      run(8'h35, 1, 0);
      check(r, 8'h00, "sus");
      end_of_test;
   end
endmodule // test_flash_cfg_protect
